// File: rtl/dprm_ctrl.sv
// Mode control, output adjustment and status registers of the loop
// Behaviour
// (R1) Two-bit frequency field picks 8 kHz, 1.544 MHz, 2.048 MHz or reserved.
// (R2) Software keeps frequency field at 00 when internal source is chosen.
// (R3) Source bit low takes reference pin; high takes internal 8 kHz from frame/clock.
// (R4) Serial data inputs refused while frame pulse or clock is absent.
// (R5) System restores frame pulse and clock after internal reference fails.
// (R6) Free-run low and control bit 14 low gives master mode.
// (R7) Free-run high and control bit 14 low gives free-run mode.
// (R8) Control bit 14 high makes the free-run bit irrelevant.
// (R9) Three-bit skew delays outputs 0 to 13.3 ns in 1.9 ns steps.
// (R10) Skew and offset ignored in free-run or bypass mode.
// (R11) Signed offset advances or delays outputs; sign picks direction.
// (R12) Offset step 15.2 ns for 8 kHz or 2.048 MHz reference.
// (R13) Offset step 20.2 ns for 1.544 MHz reference.
// (R14) Housekeeping register shows frequency status and limit flag, read-only.
`timescale 1ns/1ps
module dprm_ctrl #(
   parameter int LOSS_CYCLES = dprm_pkg::LOSS_CYCLES
) (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic [7:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [15:0] rdata_out,
   input wire logic bypass_in,
   input wire logic ext_ref_in,
   input wire logic frame_pulse_in,
   input wire logic serial_clock_in,
   input wire logic ref_freq_ok_in,
   input wire logic loop_limit_in,
   output logic loop_ref_out,
   output logic [1:0] ref_freq_sel_out,
   output logic [1:0] loop_mode_out,
   output logic ref_invert_out,
   output logic [2:0] output_skew_ctl_out,
   output logic [15:0] skew_delay_ps_out,
   output logic signed [12:0] output_offset_out,
   output logic [15:0] offset_step_ps_out,
   output logic serial_input_enable_out
);
   initial begin
      if (LOSS_CYCLES < 2 || LOSS_CYCLES > 1048575) begin
         $error("LOSS_CYCLES out of range");
      end
   end

   dprm_pkg::dprm_bus_t bus;
   assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

   logic [15:0] mode_q;
   logic [15:0] adjust_q;
   logic [15:0] rdata_q;

   // Async pins pass two flops before use
   logic [4:0] sync1_q;
   logic [4:0] sync2_q;
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         sync1_q <= 5'h00;
         sync2_q <= 5'h00;
      end else begin
         sync1_q <= {ext_ref_in, frame_pulse_in, serial_clock_in, ref_freq_ok_in, loop_limit_in};
         sync2_q <= sync1_q;
      end
   end
   logic ext_ref_s, fp_s, ck_s, freq_ok_s, limit_s;
   assign {ext_ref_s, fp_s, ck_s, freq_ok_s, limit_s} = sync2_q;

   // Register writes; reserved bits forced to zero
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         mode_q <= dprm_pkg::MODE_RESET;
         adjust_q <= dprm_pkg::ADJ_RESET;
      end else if (bus.wr) begin
         if (bus.addr == dprm_pkg::OFS_MODE) begin
            mode_q <= bus.wdata & dprm_pkg::MODE_WR_MASK;
         end else if (bus.addr == dprm_pkg::OFS_ADJUST) begin
            adjust_q <= bus.wdata;
         end
      end
   end

   // Status writes dropped, unmapped reads give zero
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         rdata_q <= 16'h0000;
      end else if (bus.rd) begin
         if (bus.addr == dprm_pkg::OFS_MODE) begin
            rdata_q <= mode_q;
         end else if (bus.addr == dprm_pkg::OFS_ADJUST) begin
            rdata_q <= adjust_q;
         end else if (bus.addr == dprm_pkg::OFS_STATUS) begin
            rdata_q <= {11'h000, freq_ok_s, limit_s, 3'h0}; // R14
         end else begin
            rdata_q <= 16'h0000;
         end
      end else begin
         rdata_q <= 16'h0000;
      end
   end
   assign rdata_out = rdata_q;

   // Decode of the control fields
   dprm_pkg::dprm_ctl_t ctl;
   always_comb begin
      ctl.freq = mode_q[dprm_pkg::MODE_FREQ_LSB +: 2]; // R1
      ctl.use_internal = mode_q[dprm_pkg::MODE_SRC_BIT];
      ctl.invert = mode_q[dprm_pkg::MODE_INV_BIT];
      if (bypass_in) begin
         ctl.mode = dprm_pkg::DPRM_BYPASS; // R8
      end else if (mode_q[dprm_pkg::MODE_FREERUN_BIT]) begin
         ctl.mode = dprm_pkg::DPRM_FREERUN; // R7
      end else begin
         ctl.mode = dprm_pkg::DPRM_MASTER; // R6
      end
      if (ctl.mode == dprm_pkg::DPRM_MASTER) begin
         ctl.skew = adjust_q[dprm_pkg::ADJ_SKEW_LSB +: 3]; // R9
         ctl.offset = adjust_q[dprm_pkg::ADJ_OFFSET_LSB +: dprm_pkg::ADJ_OFFSET_W]; // R11
      end else begin
         ctl.skew = 3'h0; // R10
         ctl.offset = 13'h0000; // R10
      end
      if (ctl.freq == dprm_pkg::FREQ_1544) begin
         ctl.offset_step_ps = 16'(dprm_pkg::OFS_STEP_T1_PS); // R13
      end else begin
         ctl.offset_step_ps = 16'(dprm_pkg::OFS_STEP_E1_PS); // R12
      end
   end

   // Internal 8 kHz taken from frame pulse edges
   logic fp_prev_q;
   logic ck_prev_q;
   logic int_ref_q;
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         fp_prev_q <= 1'b0;
         ck_prev_q <= 1'b0;
         int_ref_q <= 1'b0;
      end else begin
         fp_prev_q <= fp_s;
         ck_prev_q <= ck_s;
         if (fp_s && !fp_prev_q) begin
            int_ref_q <= ~int_ref_q;
         end
      end
   end

   // Loss watchdogs on frame pulse and clock activity
   logic [19:0] fp_cnt_q;
   logic [19:0] ck_cnt_q;
   logic fp_ok_q;
   logic ck_ok_q;
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         fp_cnt_q <= 20'h00000;
         fp_ok_q <= 1'b0;
      end else if (fp_s != fp_prev_q) begin
         fp_cnt_q <= 20'h00000;
         fp_ok_q <= 1'b1;
      end else if (fp_cnt_q >= 20'(LOSS_CYCLES - 1)) begin
         fp_ok_q <= 1'b0;
      end else begin
         fp_cnt_q <= fp_cnt_q + 20'h00001;
      end
   end
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         ck_cnt_q <= 20'h00000;
         ck_ok_q <= 1'b0;
      end else if (ck_s != ck_prev_q) begin
         ck_cnt_q <= 20'h00000;
         ck_ok_q <= 1'b1;
      end else if (ck_cnt_q >= 20'(LOSS_CYCLES - 1)) begin
         ck_ok_q <= 1'b0;
      end else begin
         ck_cnt_q <= ck_cnt_q + 20'h00001;
      end
   end

   // Registered outputs
   always_ff @(posedge mclk_in) begin
      if (!resetn_in) begin
         loop_ref_out <= 1'b0;
         ref_freq_sel_out <= dprm_pkg::FREQ_8K;
         loop_mode_out <= 2'h0;
         ref_invert_out <= 1'b0;
         output_skew_ctl_out <= 3'h0;
         skew_delay_ps_out <= 16'h0000;
         output_offset_out <= 13'h0000;
         offset_step_ps_out <= 16'h0000;
         serial_input_enable_out <= 1'b0;
      end else begin
         // Inversion only on the pin; internal source has fixed polarity
         loop_ref_out <= ctl.use_internal ? int_ref_q : (ext_ref_s ^ ctl.invert); // R3
         ref_freq_sel_out <= ctl.freq; // R1
         loop_mode_out <= 2'(ctl.mode);
         ref_invert_out <= ctl.invert;
         output_skew_ctl_out <= ctl.skew; // R9
         skew_delay_ps_out <= 16'(ctl.skew * dprm_pkg::SKEW_STEP_PS); // R9
         output_offset_out <= ctl.offset; // R11
         offset_step_ps_out <= ctl.offset_step_ps;
         serial_input_enable_out <= fp_ok_q && ck_ok_q; // R4
      end
   end
endmodule

// File: rtl/dprm_pkg.sv
// Package of constants and carriers for the loop mode and adjustment block
package dprm_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam logic [7:0] OFS_MODE = 8'h30;
   localparam logic [7:0] OFS_ADJUST = 8'h32;
   localparam logic [7:0] OFS_STATUS = 8'h34;
   localparam int MODE_FREERUN_BIT = 0;
   localparam int MODE_SRC_BIT = 1;
   localparam int MODE_FREQ_LSB = 3;
   localparam int MODE_INV_BIT = 7;
   localparam logic [15:0] MODE_WR_MASK = 16'h009b;
   localparam logic [15:0] MODE_RESET = 16'h0000;
   localparam int ADJ_SKEW_LSB = 0;
   localparam int ADJ_OFFSET_LSB = 3;
   localparam int ADJ_OFFSET_W = 13;
   localparam logic [15:0] ADJ_RESET = 16'h0000;
   localparam int STAT_LIMIT_BIT = 3;
   localparam int STAT_FREQ_BIT = 4;
   localparam logic [1:0] FREQ_8K = 2'h0;
   localparam logic [1:0] FREQ_1544 = 2'h1;
   localparam logic [1:0] FREQ_2048 = 2'h2;
   localparam logic [1:0] FREQ_RSVD = 2'h3;
   localparam int SKEW_STEP_PS = 1900;
   localparam int SKEW_MAX_PS = 13300;
   localparam int OFS_STEP_E1_PS = 15200;
   localparam int OFS_STEP_T1_PS = 20200;
   localparam int CLK_PERIOD_NS = 100;
   localparam int LOSS_TIME_NS = 250000;
   localparam int LOSS_CYCLES = LOSS_TIME_NS / CLK_PERIOD_NS;
   typedef enum logic [1:0] {DPRM_MASTER, DPRM_FREERUN, DPRM_BYPASS} dprm_mode_t;
   typedef struct packed {
      logic [7:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } dprm_bus_t;
   typedef struct packed {
      dprm_mode_t mode;
      logic use_internal;
      logic [1:0] freq;
      logic invert;
      logic [2:0] skew;
      logic signed [12:0] offset;
      logic [15:0] offset_step_ps;
   } dprm_ctl_t;
endpackage

// File: verif/dprm_ctrl_checker.sv
// Assertions on the loop control block ports
`timescale 1ns/1ps
module dprm_ctrl_checker #(parameter int LOSS_CYCLES = 20) (
   input wire logic mclk_in,
   input wire logic resetn_in,
   input wire logic [7:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   input wire logic [15:0] rdata_out,
   input wire logic bypass_in,
   input wire logic frame_pulse_in,
   input wire logic [1:0] ref_freq_sel_out,
   input wire logic [1:0] loop_mode_out,
   input wire logic [2:0] output_skew_ctl_out,
   input wire logic signed [12:0] output_offset_out,
   input wire logic [15:0] offset_step_ps_out,
   input wire logic serial_input_enable_out
);
   logic fp_q;
   logic [15:0] quiet_q;
   // Saturates so a long idle cannot wrap
   always_ff @(posedge mclk_in) begin
      fp_q <= frame_pulse_in;
      quiet_q <= (!resetn_in || fp_q != frame_pulse_in) ? 16'h0 : quiet_q + {15'h0, ~&quiet_q};
   end
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!resetn_in);
   sequence mode_wr_s;
      wr_in && addr_in == dprm_pkg::OFS_MODE && !bypass_in ##1 !bypass_in;
   endsequence
   mode_wr_a: assert property (mode_wr_s |=> loop_mode_out == {1'b0, $past(wdata_in[0], 2)})
      else $error("mode not set by write");
   freq_wr_a: assert property (mode_wr_s |=> ref_freq_sel_out == $past(wdata_in[4:3], 2))
      else $error("frequency field not set by write");
   bypass_mode_a: assert property ($past(resetn_in) && $past(resetn_in, 2) && $past(bypass_in) && $past(bypass_in, 2)
      |-> loop_mode_out == 2'h2) else $error("bypass not honoured");
   adj_ignored_a: assert property (loop_mode_out != 2'h0 |-> output_skew_ctl_out == 3'h0 && output_offset_out == 13'h0)
      else $error("adjustment leaks outside master");
   step_size_a: assert property ($past(resetn_in) && $stable(ref_freq_sel_out)
      |-> offset_step_ps_out == (ref_freq_sel_out == 2'h1 ? 16'h4ee8 : 16'h3b60)) else $error("offset step wrong");
   rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == 16'h0)
      else $error("read data outside read slot");
   stat_zero_a: assert property ($past(rd_in && addr_in == dprm_pkg::OFS_STATUS) |-> rdata_out[15:5] == 11'h0)
      else $error("status upper bits set");
   input_loss_a: assert property (int'(quiet_q) > LOSS_CYCLES + 8 |-> !serial_input_enable_out)
      else $error("inputs accepted without frame pulse");
endmodule
bind dprm_ctrl dprm_ctrl_checker #(.LOSS_CYCLES(LOSS_CYCLES)) chk_u (.*);

// File: verif/dprm_ctrl_test.sv
// Self-checking bench for the loop mode and adjustment registers
`timescale 1ns/1ps
module dprm_ctrl_test;
   logic mclk_in = 1'b0, resetn_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, bypass_in = 1'b0, run = 1'b0;
   logic ref_freq_ok_in = 1'b0, loop_limit_in = 1'b0;
   logic ext_ref_in, frame_pulse_in, serial_clock_in, loop_ref_out, ref_invert_out, serial_input_enable_out;
   logic [7:0] addr_in = 8'h0;
   logic [15:0] wdata_in = 16'h0, rdata_out, skew_delay_ps_out, offset_step_ps_out, v;
   logic [1:0] ref_freq_sel_out, loop_mode_out;
   logic [2:0] output_skew_ctl_out;
   logic signed [12:0] output_offset_out;
   int n_mismatch = 0, compares = 0, cyc = 0;
   // Watchdog must outlast the partner's 28-cycle gap between frame pulse edges
   dprm_ctrl #(.LOSS_CYCLES(40)) dut_u (.*);
   dprm_partner far_u (.mclk_in(mclk_in), .run_in(run), .frame_pulse_out(frame_pulse_in),
      .serial_clock_out(serial_clock_in), .ext_ref_out(ext_ref_in));
   task automatic ck(input logic [15:0] g, input logic [15:0] e);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk_in);
      wr_in <= 1'b1;
      addr_in <= a;
      wdata_in <= d;
      @(posedge mclk_in);
      wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge mclk_in);
      rd_in <= 1'b1;
      addr_in <= a;
      @(posedge mclk_in);
      rd_in <= 1'b0;
      @(negedge mclk_in);
      v = rdata_out;
   endtask
   task automatic st(input int n);
      repeat (n) @(posedge mclk_in);
      @(negedge mclk_in);
   endtask
   task automatic t_regs();
      wr(8'h30, 16'hffff);
      rd(8'h30);
      ck(v, 16'h009b);
      rd(8'h40);
      ck(v, 16'h0000);
      for (int i = 1; i < 3; i++) begin
         @(posedge mclk_in);
         {ref_freq_ok_in, loop_limit_in} <= 2'(i);
         wr(8'h34, 16'hffff);
         st(4);
         rd(8'h34);
         ck(v & 16'hfff8, 16'(i) << 3);
      end
      $display("regs done");
   endtask
   task automatic t_modes();
      for (int i = 0; i < 8; i++) begin
         wr(8'h30, {11'h0, 2'(i >> 1), 2'h0, 1'(i)});
         st(1);
         ck({12'h0, ref_freq_sel_out, loop_mode_out}, {12'h0, 2'(i >> 1), 2'(i & 1)});
         ck(offset_step_ps_out, (i >> 1) == 1 ? 16'h4ee8 : 16'h3b60);
      end
      $display("modes done");
   endtask
   task automatic t_adj();
      wr(8'h30, 16'h0010);
      wr(8'h32, 16'hffff);
      st(1);
      ck({output_skew_ctl_out, output_offset_out}, 16'hffff);
      ck(skew_delay_ps_out, 16'h33f4);
      wr(8'h32, 16'h0029);
      st(1);
      ck({output_skew_ctl_out, output_offset_out}, 16'h2005);
      ck(skew_delay_ps_out, 16'h076c);
      wr(8'h30, 16'h0011);
      st(1);
      ck({output_skew_ctl_out, output_offset_out}, 16'h0);
      @(posedge mclk_in);
      bypass_in <= 1'b1;
      wr(8'h30, 16'h0010);
      st(1);
      ck({loop_mode_out, output_offset_out, 1'b0}, 16'h8000);
      @(posedge mclk_in);
      bypass_in <= 1'b0;
      $display("adjust done");
   endtask
   task automatic t_src();
      int n;
      logic p;
      @(posedge mclk_in);
      run <= 1'b0;
      wr(8'h30, 16'h0000);
      st(60);
      ck({15'h0, loop_ref_out}, {15'h0, ext_ref_in});
      ck({15'h0, serial_input_enable_out}, 16'h0);
      wr(8'h30, 16'h0080);
      st(2);
      ck({15'h0, loop_ref_out}, {15'h0, ~ext_ref_in});
      ck({15'h0, ref_invert_out}, 16'h1);
      wr(8'h30, 16'h0002);
      for (int k = 0; k < 2; k++) begin
         n = 0;
         p = loop_ref_out;
         repeat (200) begin
            @(negedge mclk_in);
            n += int'(loop_ref_out !== p);
            p = loop_ref_out;
         end
         ck(16'(n > 3), 16'(k));
         @(posedge mclk_in);
         run <= 1'b1;
      end
      ck({15'h0, serial_input_enable_out}, 16'h1);
      $display("source done");
   endtask
   task automatic results();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      forever #50 mclk_in = ~mclk_in;
   end
   // Whole run needs under a thousand cycles
   always @(posedge mclk_in) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_mismatch++;
         results();
      end
   end
   initial begin
      repeat (5) @(posedge mclk_in);
      resetn_in <= 1'b1;
      run <= 1'b1;
      t_regs();
      t_modes();
      t_adj();
      t_src();
      results();
   end
endmodule

// File: verif/dprm_partner.sv
// Far-side timing source: frame pulse, serial clock and reference pin
`timescale 1ns/1ps
module dprm_partner (
   input wire logic mclk_in,
   input wire logic run_in,
   output logic frame_pulse_out,
   output logic serial_clock_out,
   output logic ext_ref_out
);
   logic [4:0] div_q = 5'h0;
   always_ff @(posedge mclk_in) begin
      if (run_in) begin
         div_q <= div_q + 5'h1;
      end
   end
   // A lost frame pulse or clock parks low, so loss detection sees no edges; the reference pin holds its level
   assign serial_clock_out = run_in & div_q[1];
   assign frame_pulse_out = run_in & (div_q[4:2] == 3'h0);
   assign ext_ref_out = div_q[4];
endmodule
